// ### inc/ebc_pkg.sv
// Package for the byte access controller of the data nonvolatile memory.
// Assumes a single 50 MHz core clock and an 8-bit register port.
package ebc_pkg;

  // ****************************************
  // Register offsets (I/O space)
  // ****************************************
  localparam logic [5:0] OFS_CONTROL = 6'h1C;
  localparam logic [5:0] OFS_DATA = 6'h1D;
  localparam logic [5:0] OFS_ADDR_LOW = 6'h1E;
  localparam logic [5:0] OFS_ADDR_HIGH = 6'h1F;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int BIT_READ = 0;
  localparam int BIT_GO = 1;
  localparam int BIT_ARM = 2;
  localparam int BIT_RDY_IE = 3;
  localparam int BIT_MODE_LO = 4;

  // ****************************************
  // Mode encodings and reset values
  // ****************************************
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 50;
  localparam int ARM_CYCLES = 4;
  localparam int READ_STALL = 4;
  localparam int PROG_STALL = 2;
  localparam int OSC_DIV = 8;
  localparam int T_ATOMIC_US = 3400;
  localparam int T_SPLIT_US = 1800;
  // Multiply before dividing: the divided rate is not a whole number of MHz
  localparam int TICKS_ATOMIC = T_ATOMIC_US * CLK_MHZ / OSC_DIV;
  localparam int TICKS_SPLIT = T_SPLIT_US * CLK_MHZ / OSC_DIV;

endpackage

// ### inc/ebc_mem_if.sv
// Interface between the controller and its byte array.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
interface ebc_mem_if #(parameter int AW = 9);
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic erase;
  logic write;
  logic [7:0] rdata;
  modport ctrl (output addr, output wdata, output erase, output write, input rdata);
  modport mem (input addr, input wdata, input erase, input write, output rdata);
endinterface

// ### src/ebc_array.sv
// Byte array standing in for the nonvolatile cells.
// Assumes one erase, write or combined erase-and-write strobe at a time from the controller.
`timescale 1ns/10ps
module ebc_array #(
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  input wire logic mclk,
  ebc_mem_if.mem port
);
  logic [7:0] cell_q [DEPTH];
  logic [7:0] cell_d [DEPTH];

  // Contents are nonvolatile, so reset does not touch them
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_cell
      always_comb begin
        cell_d[i] = cell_q[i];
        if (port.addr == AW'(i)) begin
          if (port.erase && port.write) begin
            cell_d[i] = port.wdata;
          end else if (port.erase) begin
            cell_d[i] = ebc_pkg::ERASED_BYTE;
          end else if (port.write) begin
            // Writing only clears bits, as on an unerased cell
            cell_d[i] = cell_q[i] & port.wdata;
          end
        end
      end
      always_ff @(posedge mclk) begin
        cell_q[i] <= cell_d[i];
      end
    end
  endgenerate

  assign port.rdata = cell_q[port.addr];
endmodule

// ### src/ebc_timer.sv
// Self-timer for programming, clocked by the oscillator enable.
// Assumes osc_tick is a one-cycle pulse on mclk.
`timescale 1ns/10ps
module ebc_timer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic osc_tick,
  input wire logic start,
  input wire logic [31:0] ticks,
  output logic done
);
  logic [31:0] cnt_q, cnt_d;
  logic done_d;

  always_comb begin
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d = ticks;
    end else if (osc_tick && cnt_q != 32'h0) begin
      cnt_d = cnt_q - 32'h1;
      done_d = (cnt_q == 32'h1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
      done <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done <= done_d;
    end
  end
endmodule

// ### src/ebc_ctrl.sv
// Byte access controller for the data nonvolatile memory.
// Assumes a core that writes and reads the registers over a plain strobe port.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/10ps

// Functional notes
// - Linear byte-addressed space of 128/256/512
// - Read stalls core four cycles
// - Program start stalls core two cycles
// - Go counts only within four cycles of arm
// - Mode 00 erases then writes atomically
// - Mode 01 erases only
// - Mode 10 writes only, no erase
// - Go bit stays set until finished
// - No other access while programming; address and data register writes still take effect
// - Durations timed from the internal oscillator
// - Address then read strobe loads data
// - Registers sit in I/O space
// - Arm bit self-clears after four cycles
// - Mode locked while busy; reset clears if idle
// - Atomic 3.4 ms, split 1.8 ms
// - Ready request while enabled and global enable
module ebc_ctrl #(
  parameter int DEPTH = 512,
  parameter int AW = 9,
  parameter int TICKS_ATOMIC = ebc_pkg::TICKS_ATOMIC,
  parameter int TICKS_SPLIT = ebc_pkg::TICKS_SPLIT
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic global_irq_en,
  output logic [7:0] io_rdata,
  output logic cpu_stall,
  output logic ready_irq
);
  // ****************************************
  // Internal wiring
  // ****************************************
  ebc_mem_if #(.AW(AW)) mem ();
  logic osc_tick;
  logic timer_done;
  logic timer_start;
  logic [31:0] timer_ticks;

  typedef enum logic [1:0] {ST_IDLE, ST_PROG} ebc_state_e;
  ebc_state_e state_q, state_d;

  logic [AW-1:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;
  logic [1:0] mode_q, mode_d;
  logic [1:0] op_mode_q, op_mode_d;
  logic rdy_ie_q, rdy_ie_d;
  logic arm_q, arm_d;
  logic [2:0] arm_cnt_q, arm_cnt_d;
  logic go_q, go_d;
  logic [2:0] stall_q, stall_d;
  logic [2:0] div_q, div_d;
  logic erase_d, write_d;
  logic [7:0] rdata_d;
  logic irq_d;
  logic wr_ctl;

  assign wr_ctl = io_wr && io_addr == ebc_pkg::OFS_CONTROL;

  // ****************************************
  // Oscillator enable and self-timer
  // ****************************************
  // Stand-in for the calibrated oscillator: a divided enable on mclk
  always_comb begin
    div_d = div_q + 3'h1;
    osc_tick = (div_q == 3'(ebc_pkg::OSC_DIV - 1));
    if (osc_tick) begin
      div_d = 3'h0;
    end
  end

  ebc_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .osc_tick(osc_tick),
    .start(timer_start),
    .ticks(timer_ticks),
    .done(timer_done)
  );

  ebc_array #(.DEPTH(DEPTH), .AW(AW)) u_array (
    .mclk(mclk),
    .port(mem.mem)
  );

  assign mem.addr = addr_q;
  assign mem.wdata = data_q;
  assign mem.erase = erase_d;
  assign mem.write = write_d;

  // ****************************************
  // Register and sequencing logic
  // ****************************************
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    data_d = data_q;
    mode_d = mode_q;
    op_mode_d = op_mode_q;
    rdy_ie_d = rdy_ie_q;
    arm_d = arm_q;
    arm_cnt_d = arm_cnt_q;
    go_d = go_q;
    stall_d = stall_q;
    erase_d = 1'b0;
    write_d = 1'b0;
    timer_start = 1'b0;
    timer_ticks = 32'(TICKS_SPLIT);

    if (stall_q != 3'h0) begin
      stall_d = stall_q - 3'h1;
    end

    // Arm window closes by itself
    if (arm_q) begin
      if (arm_cnt_q == 3'h1) begin
        arm_d = 1'b0;
      end
      arm_cnt_d = arm_cnt_q - 3'h1;
    end

    if (io_wr) begin
      case (io_addr)
        ebc_pkg::OFS_ADDR_LOW: addr_d[(AW > 8 ? 7 : AW-1):0] = io_wdata[(AW > 8 ? 7 : AW-1):0];
        ebc_pkg::OFS_ADDR_HIGH: begin
          if (AW > 8) begin
            addr_d[AW-1] = io_wdata[0];
          end
        end
        ebc_pkg::OFS_DATA: data_d = io_wdata;
        default: begin
        end
      endcase
    end

    if (wr_ctl) begin
      rdy_ie_d = io_wdata[ebc_pkg::BIT_RDY_IE];
      if (!go_q) begin
        mode_d = io_wdata[ebc_pkg::BIT_MODE_LO +: 2];
      end
      if (io_wdata[ebc_pkg::BIT_ARM] && !go_q) begin
        arm_d = 1'b1;
        arm_cnt_d = 3'(ebc_pkg::ARM_CYCLES);
      end
      // Start only from an already armed state, not the same write
      if (io_wdata[ebc_pkg::BIT_GO] && arm_q && !go_q) begin
        go_d = 1'b1;
        arm_d = 1'b0;
        op_mode_d = mode_q;
        state_d = ST_PROG;
        stall_d = 3'(ebc_pkg::PROG_STALL);
        timer_start = 1'b1;
        timer_ticks = (mode_q == ebc_pkg::MODE_ATOMIC) ? 32'(TICKS_ATOMIC) : 32'(TICKS_SPLIT);
      end else if (io_wdata[ebc_pkg::BIT_READ] && !go_q) begin
        data_d = mem.rdata;
        stall_d = 3'(ebc_pkg::READ_STALL);
      end
    end

    case (state_q)
      ST_IDLE: begin
      end
      ST_PROG: begin
        if (timer_done) begin
          case (op_mode_q)
            ebc_pkg::MODE_ATOMIC: begin
              erase_d = 1'b1;
              write_d = 1'b1;
            end
            ebc_pkg::MODE_ERASE: erase_d = 1'b1;
            ebc_pkg::MODE_WRITE: write_d = 1'b1;
            default: begin
            end
          endcase
          go_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase

    irq_d = rdy_ie_q && global_irq_en && !go_q;

    rdata_d = 8'h00;
    if (io_rd) begin
      case (io_addr)
        ebc_pkg::OFS_CONTROL: rdata_d = {2'b00, mode_q, rdy_ie_q, arm_q, go_q, 1'b0};
        ebc_pkg::OFS_DATA: rdata_d = data_q;
        ebc_pkg::OFS_ADDR_LOW: rdata_d = 8'(addr_q);
        ebc_pkg::OFS_ADDR_HIGH: rdata_d = {7'h00, (AW > 8) ? addr_q[AW-1] : 1'b0};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      addr_q <= '0;
      data_q <= ebc_pkg::RST_DATA;
      op_mode_q <= ebc_pkg::RST_MODE;
      rdy_ie_q <= 1'b0;
      arm_q <= 1'b0;
      arm_cnt_q <= 3'h0;
      go_q <= 1'b0;
      stall_q <= 3'h0;
      div_q <= 3'h0;
      io_rdata <= 8'h00;
      cpu_stall <= 1'b0;
      ready_irq <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      data_q <= data_d;
      op_mode_q <= op_mode_d;
      rdy_ie_q <= rdy_ie_d;
      arm_q <= arm_d;
      arm_cnt_q <= arm_cnt_d;
      go_q <= go_d;
      stall_q <= stall_d;
      div_q <= div_d;
      io_rdata <= rdata_d;
      cpu_stall <= (stall_d != 3'h0);
      ready_irq <= irq_d;
    end
  end

  // Mode field holds through one reset cycle while a program runs; go clears there, so a longer reset clears it
  always_ff @(posedge mclk) begin
    if (!rst_n && !go_q) begin
      mode_q <= ebc_pkg::RST_MODE;
    end else if (rst_n) begin
      mode_q <= mode_d;
    end
  end
endmodule

// ### verification/ebc_chk.sv
// Checker for the controller's register port, stall and ready request.
// Assumes it is bound to ebc_ctrl and sees only its ports.
`timescale 1ns/10ps
module ebc_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic global_irq_en,
  input wire logic [7:0] io_rdata,
  input wire logic cpu_stall,
  input wire logic ready_irq
);
  // ****************************************
  // Cycles since the last arm write
  // ****************************************
  logic [2:0] age_q;
  logic [2:0] age_d;
  logic ctl_wr;
  logic go_ok;
  logic go_bad;
  assign ctl_wr = io_wr && io_addr == ebc_pkg::OFS_CONTROL;
  // Ready high stands in for idle, since busy is not visible at the ports
  assign go_ok = ctl_wr && io_wdata[1] && !io_wdata[2] && age_q inside {3'h1, 3'h2} && ready_irq;
  assign go_bad = ctl_wr && io_wdata[1] && age_q == 3'h7 && ready_irq;
  always_comb begin
    age_d = age_q;
    if (ctl_wr && io_wdata[2]) begin
      age_d = 3'h1;
    end else if (age_q != 3'h7) begin
      age_d = age_q + 3'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      age_q <= 3'h7;
    end else begin
      age_q <= age_d;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!$past(io_rd) |-> io_rdata == 8'h00) else $error("read data outside read cycle");
  a_read_stall: assert property (ctl_wr && io_wdata[0] && ready_irq && !cpu_stall |=>
    cpu_stall [*4] ##1 !cpu_stall) else $error("read stall length wrong");
  a_prog_stall: assert property (go_ok |=> cpu_stall [*2] ##1 !cpu_stall) else $error("program stall wrong");
  a_busy_ready: assert property (go_ok |-> ##2 !ready_irq) else $error("ready while busy");
  a_go_refused: assert property (go_bad |=> !cpu_stall ##1 ready_irq) else $error("start without arm");
  a_ready_gie: assert property (!$past(global_irq_en) |-> !ready_irq) else $error("ready without enable");
  a_stall_cause: assert property ($rose(cpu_stall) |->
    $past(ctl_wr && io_wdata[1:0] != 2'h0)) else $error("stall without cause");
  a_ctrl_zero: assert property ($past(io_rd && io_addr == ebc_pkg::OFS_CONTROL) |->
    io_rdata[7:6] == 2'h0 && !io_rdata[0]) else $error("control bits not zero");
  c_go: cover property (go_ok);
  c_refused: cover property (go_bad);
  c_read: cover property (ctl_wr && io_wdata[0] && ready_irq);
endmodule

// ### verification/ebc_core.sv
// Model of the processor core driving the register port.
// Assumes callers enter its tasks just after a rising mclk edge.
`timescale 1ns/10ps
module ebc_core (
  input wire logic mclk,
  input wire logic cpu_stall,
  input wire logic [7:0] io_rdata,
  output logic [5:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_wr,
  output logic io_rd
);
  int stuck;
  initial begin
    stuck = 0;
    io_addr = 6'h00;
    io_wdata = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
  end
  // A stalled core issues nothing
  task automatic hold;
    int n;
    n = 0;
    while (cpu_stall === 1'b1 && n < 16) begin
      @(posedge mclk);
      n++;
    end
    // A stall that never ends is counted by the bench as a mismatch
    if (cpu_stall === 1'b1) begin
      stuck++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    hold();
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge mclk);
    io_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    hold();
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge mclk);
    io_rd <= 1'b0;
    // Read data are settled in the middle of the cycle after the strobe
    @(negedge mclk);
    d = io_rdata;
    @(posedge mclk);
  endtask
endmodule

// ### verification/eeprom_byte_access_controller_bench.sv
// Self-checking bench for the byte access controller.
// Assumes the core model and the checker are compiled beside it.
`timescale 1ns/10ps
module eeprom_byte_access_controller_bench;
  localparam logic [5:0] CT = ebc_pkg::OFS_CONTROL;
  localparam logic [5:0] DT = ebc_pkg::OFS_DATA;
  localparam int TA = 6;
  localparam int TS = 3;
  typedef struct packed {logic [1:0] m; logic [8:0] a; logic [7:0] d; logic [7:0] e;} ebc_row_s;
  logic mclk;
  logic rst_n;
  logic gie;
  logic [5:0] io_addr;
  logic [7:0] io_wdata;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_rdata;
  logic cpu_stall;
  logic ready_irq;
  logic [7:0] v;
  int error_cnt;
  int total_checks;
  ebc_row_s rows [6];
  ebc_core core (.mclk(mclk), .cpu_stall(cpu_stall), .io_rdata(io_rdata), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd));
  // Short timer counts keep each programming run to a few dozen cycles
  ebc_ctrl #(.TICKS_ATOMIC(TA), .TICKS_SPLIT(TS)) dut (.mclk(mclk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .global_irq_en(gie), .io_rdata(io_rdata),
    .cpu_stall(cpu_stall), .ready_irq(ready_irq));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic print_verdict;
    error_cnt += core.stuck;
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic poll;
    int n;
    n = 0;
    core.rd(CT, v);
    while (v[1] !== 1'b0) begin
      n++;
      if (n > 200) begin
        error_cnt++;
        print_verdict();
      end
      core.rd(CT, v);
    end
  endtask
  task automatic prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d);
    poll();
    core.wr(CT, {2'h0, m, 4'h8});
    core.wr(ebc_pkg::OFS_ADDR_LOW, a[7:0]);
    core.wr(ebc_pkg::OFS_ADDR_HIGH, {7'h00, a[8]});
    core.wr(DT, d);
    core.wr(CT, {2'h0, m, 4'hC});
    core.wr(CT, {2'h0, m, 4'hA});
    core.rd(CT, v);
    chk(v & 8'hFB, {2'h0, m, 4'hA});
    chk({7'h00, ready_irq}, 8'h00);
  endtask
  // Edges from the start write to the end of the first idle read; prog returns five edges after the start
  task automatic span(input int t);
    int c;
    c = 5;
    v = 8'h02;
    while (v[1] !== 1'b0 && c < 400) begin
      core.rd(CT, v);
      c += 2;
    end
    chk({7'h00, c >= ebc_pkg::OSC_DIV * t - 4 && c <= ebc_pkg::OSC_DIV * t + 4}, 8'h01);
    if (c >= 400) begin
      print_verdict();
    end
  endtask
  task automatic fetch(input logic [8:0] a);
    poll();
    core.wr(ebc_pkg::OFS_ADDR_LOW, a[7:0]);
    core.wr(ebc_pkg::OFS_ADDR_HIGH, {7'h00, a[8]});
    core.wr(CT, 8'h09);
    core.rd(DT, v);
  endtask
  initial begin
    rst_n = 1'b0;
    gie = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    // Write-only goes to a byte erased just before
    rows = '{'{2'h0, 9'h000, 8'h5A, 8'h5A}, '{2'h0, 9'h1FF, 8'hC3, 8'hC3}, '{2'h1, 9'h1FF, 8'h00, 8'hFF},
      '{2'h2, 9'h1FF, 8'h3C, 8'h3C}, '{2'h3, 9'h000, 8'h00, 8'h5A}, '{2'h0, 9'h080, 8'hA5, 8'hA5}};
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    core.rd(CT, v);
    chk(v, 8'h00);
    core.rd(DT, v);
    chk(v, ebc_pkg::RST_DATA);
    core.wr(CT, 8'h08);
    chk({7'h00, ready_irq}, 8'h00);
    gie <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({7'h00, ready_irq}, 8'h01);
    foreach (rows[i]) begin
      prog(rows[i].m, rows[i].a, rows[i].d);
      if (rows[i].m != ebc_pkg::MODE_RSVD) begin
        span((rows[i].m == ebc_pkg::MODE_ATOMIC) ? TA : TS);
      end
      fetch(rows[i].a);
      chk(v, rows[i].e);
    end
    prog(ebc_pkg::MODE_ATOMIC, 9'h080, 8'h77);
    core.wr(CT, 8'h18);
    core.rd(CT, v);
    chk(v & 8'hFB, 8'h0A);
    core.wr(CT, 8'h09);
    core.rd(DT, v);
    chk(v, 8'h77);
    fetch(9'h080);
    chk(v, 8'h77);
    core.wr(CT, 8'h0C);
    core.rd(CT, v);
    chk(v, 8'h0C);
    repeat (4) @(posedge mclk);
    core.rd(CT, v);
    chk(v, 8'h08);
    core.wr(CT, 8'h0A);
    core.rd(CT, v);
    chk(v, 8'h08);
    core.wr(CT, 8'h0E);
    core.rd(CT, v);
    chk(v & 8'hFB, 8'h08);
    // Mode written while idle, then cleared by a reset while still idle
    core.wr(CT, 8'h18);
    core.rd(CT, v);
    chk(v & 8'hFB, 8'h18);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    core.rd(CT, v);
    chk(v, 8'h00);
    print_verdict();
  end
endmodule
bind ebc_ctrl ebc_chk u_chk (.mclk(mclk), .rst_n(rst_n), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
  .io_rd(io_rd), .global_irq_en(global_irq_en), .io_rdata(io_rdata), .cpu_stall(cpu_stall), .ready_irq(ready_irq));
